/* design/sldr_pkg.sv */
// Constants for the squib loop diagnostic register bank
`default_nettype none
package sldr_pkg;
    // ------------------------------------------------------------
    // Frame and register map
    // ------------------------------------------------------------
    localparam int          FRAME_BITS   = 32;
    localparam int          CNT_W        = 6;
    localparam logic [5:0]  FRAME_LAST   = 6'h1f;
    localparam int          RW_POS       = 31;
    localparam int          ADDR_HI      = 30;
    localparam int          ADDR_LO      = 24;
    localparam int          REG_W        = 20;
    localparam logic [6:0]  ADDR_REQUEST = 7'h38;
    localparam logic [6:0]  ADDR_RESULT  = 7'h37;
    localparam logic [19:0] REQUEST_RST  = 20'h00007;
    localparam logic [19:0] RESULT_RST   = 20'h00000;
    localparam logic [19:0] REQUEST_WMSK = 20'h0ffff;
    // ------------------------------------------------------------
    // Request register fields
    // ------------------------------------------------------------
    localparam int          DIAG_LEVEL_POS  = 15;
    localparam int          CURR_CHOICE_POS = 14;
    localparam int          PULLDOWN_POS    = 13;
    localparam int          SRC_HI          = 12;
    localparam int          SRC_LO          = 11;
    localparam int          SINK_POS        = 10;
    localparam int          MON_HI          = 9;
    localparam int          MON_LO          = 8;
    localparam int          RES_CH_HI       = 7;
    localparam int          RES_CH_LO       = 4;
    localparam int          LEAK_CH_HI      = 3;
    localparam int          LEAK_CH_LO      = 0;
    localparam logic [1:0]  SRC_OFF         = 2'h0;
    localparam logic [1:0]  SRC_40MA        = 2'h1;
    localparam logic [1:0]  SRC_BYPASS      = 2'h2;
    // ------------------------------------------------------------
    // Result register fields
    // ------------------------------------------------------------
    localparam int          RES_LEAK_HI  = 3;
    localparam int          RES_LEAK_LO  = 0;
    localparam int          RES_PIN_POS  = 4;
    localparam int          RES_BAT_POS  = 5;
    localparam int          RES_GND_POS  = 6;
    localparam int          RES_LOOP_POS = 7;
    localparam int          NUM_CH       = 4;
endpackage
`default_nettype wire

/* design/sldr_regs.sv */
// Squib loop diagnostic request and result registers behind the SPI port
//
// Overview of operation
// - Loops shorted flag 1 when short found.
// - Ground short flag 1 when detected.
// - Battery short flag 1 when detected.
// - Tested pin bit: return 0, feed 1.
// - Leakage channel field, codes 0 to 3.
// - Leakage outcome updates flags, pin, channel.
// - Results clear on reset, else diagnostic-only updates.
// - Source control acts on resistance channel; 00 off.
// - Code 01 drives 40 mA on selected channel.
// - Request reset by safing reset; SPI writes only.
// - Code 10 bypass on selected; 11 off.
// - Sink on selected channel only when bit set.
// - Resistance channel field; 0100-1111 selects none.
// - Leakage channel field selects leakage/FET test channel.
`timescale 1ns/1ps
`default_nettype none
module sldr_regs (
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    input  wire logic                          spi_sclk_i,
    input  wire logic                          spi_cs_n_i,
    input  wire logic                          spi_mosi_i,
    output logic                               spi_miso_o,
    input  wire logic                          safing_machine_reset_i,
    input  wire logic                          loop_test_done_i,
    input  wire logic                          loops_shorted_flag_i,
    input  wire logic                          leak_test_done_i,
    input  wire logic                          ground_short_flag_i,
    input  wire logic                          battery_short_flag_i,
    input  wire logic                          tested_pin_bit_i,
    input  wire logic [3:0]                    leakage_channel_field_i,
    output logic [sldr_pkg::NUM_CH-1:0]        source_40ma_en_o,
    output logic [sldr_pkg::NUM_CH-1:0]        source_bypass_en_o,
    output logic                               source_low_current_o,
    output logic [sldr_pkg::NUM_CH-1:0]        sink_en_o,
    output logic [sldr_pkg::NUM_CH-1:0]        leak_channel_sel_o,
    output logic                               pulldown_ctrl_bit_o,
    output logic [1:0]                         regulator_current_monitor_o,
    output logic [sldr_pkg::REG_W-1:0]         loop_diag_request_o
);
    import sldr_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sclk_s_r;
    logic [2:0] csn_s_r;
    logic [1:0] mosi_s_r;

    // Stage 0 feeds only stage 1; stage 2 exists for edge detection
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_s_r <= 3'h0;
            csn_s_r  <= 3'h7;
            mosi_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], spi_sclk_i};
            csn_s_r  <= {csn_s_r[1:0], spi_cs_n_i};
            mosi_s_r <= {mosi_s_r[0], spi_mosi_i};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic frame_end;
    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
    assign cs_active = ~csn_s_r[1];
    assign frame_end = csn_s_r[1] & ~csn_s_r[2];

    // ------------------------------------------------------------
    // Frame shifter and register state
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] rx_r;
    logic [FRAME_BITS-1:0] rx_nxt;
    logic [FRAME_BITS-1:0] tx_r;
    logic [FRAME_BITS-1:0] tx_nxt;
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cnt_nxt;
    logic [REG_W-1:0]      req_r;
    logic [REG_W-1:0]      req_nxt;
    logic [REG_W-1:0]      res_r;
    logic [REG_W-1:0]      res_nxt;
    logic                  frame_ok;
    logic                  wr_req;
    logic [6:0]            rx_addr;
    logic [REG_W-1:0]      rd_data;

    assign frame_ok = frame_end && (cnt_r == CNT_W'(FRAME_BITS));
    assign rx_addr  = rx_r[ADDR_HI:ADDR_LO];
    assign wr_req   = frame_ok && rx_r[RW_POS] && (rx_addr == ADDR_REQUEST);

    // Read data for the answer of the next frame; top bits forced low
    always_comb begin
        rd_data = '0;
        if (rx_addr == ADDR_REQUEST) begin
            rd_data = req_r & REQUEST_WMSK;
        end else if (rx_addr == ADDR_RESULT) begin
            rd_data = res_r;
        end
    end

    // Shifting runs only while selected; a short or long frame is dropped
    always_comb begin
        rx_nxt  = rx_r;
        tx_nxt  = tx_r;
        cnt_nxt = cnt_r;
        if (frame_end) begin
            cnt_nxt = '0;
            if (frame_ok) begin
                tx_nxt = {1'b0, rx_addr, 4'h0, rd_data};
            end
        end else if (cs_active && sclk_rise) begin
            rx_nxt = {rx_r[FRAME_BITS-2:0], mosi_s_r[1]};
            if (cnt_r <= CNT_W'(FRAME_BITS)) begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end else if (cs_active && sclk_fall && (cnt_r != '0)) begin
            tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Request register: safing reset first, then SPI writes only
    always_comb begin
        req_nxt = req_r;
        if (safing_machine_reset_i) begin
            req_nxt = REQUEST_RST;
        end else if (wr_req) begin
            req_nxt = rx_r[REG_W-1:0] & REQUEST_WMSK;
        end
    end

    // Result register; reset wins over a same-cycle diagnostic outcome
    always_comb begin
        res_nxt = res_r;
        if (safing_machine_reset_i) begin
            res_nxt = RESULT_RST;
        end else begin
            if (loop_test_done_i) begin
                res_nxt[RES_LOOP_POS] = loops_shorted_flag_i;
            end
            if (leak_test_done_i) begin
                res_nxt[RES_GND_POS] = ground_short_flag_i;
                res_nxt[RES_BAT_POS] = battery_short_flag_i;
                res_nxt[RES_PIN_POS] = tested_pin_bit_i;
                res_nxt[RES_LEAK_HI:RES_LEAK_LO] = leakage_channel_field_i;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rx_r  <= '0;
            tx_r  <= '0;
            cnt_r <= '0;
            req_r <= REQUEST_RST;
            res_r <= RESULT_RST;
        end else begin
            rx_r  <= rx_nxt;
            tx_r  <= tx_nxt;
            cnt_r <= cnt_nxt;
            req_r <= req_nxt;
            res_r <= res_nxt;
        end
    end

    // ------------------------------------------------------------
    // Channel controls
    // ------------------------------------------------------------
    logic       low_level;
    logic [1:0] src_code;
    logic [3:0] res_ch;
    logic [3:0] leak_ch;
    assign low_level = ~req_r[DIAG_LEVEL_POS];
    assign src_code  = req_r[SRC_HI:SRC_LO];
    assign res_ch    = req_r[RES_CH_HI:RES_CH_LO];
    assign leak_ch   = req_r[LEAK_CH_HI:LEAK_CH_LO];

    logic [NUM_CH-1:0] src40_nxt;
    logic [NUM_CH-1:0] byp_nxt;
    logic [NUM_CH-1:0] sink_nxt;
    logic [NUM_CH-1:0] leak_nxt;
    logic [NUM_CH-1:0] src40_r;
    logic [NUM_CH-1:0] byp_r;
    logic [NUM_CH-1:0] sink_r;
    logic [NUM_CH-1:0] leak_r;

    // Codes 0100-1111 match no index, so every channel stays off
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic res_hit;
        assign res_hit     = low_level && (res_ch == 4'(c));
        assign src40_nxt[c] = res_hit && (src_code == SRC_40MA);
        assign byp_nxt[c]   = res_hit && (src_code == SRC_BYPASS);
        assign sink_nxt[c]  = res_hit && req_r[SINK_POS];
        assign leak_nxt[c]  = low_level && (leak_ch == 4'(c));
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src40_r <= '0;
            byp_r   <= '0;
            sink_r  <= '0;
            leak_r  <= '0;
        end else begin
            src40_r <= src40_nxt;
            byp_r   <= byp_nxt;
            sink_r  <= sink_nxt;
            leak_r  <= leak_nxt;
        end
    end

    // Output copies, all straight from flip-flops
    assign spi_miso_o                  = tx_r[FRAME_BITS-1];
    assign source_40ma_en_o            = src40_r;
    assign source_bypass_en_o          = byp_r;
    assign sink_en_o                   = sink_r;
    assign leak_channel_sel_o          = leak_r;
    assign source_low_current_o        = req_r[CURR_CHOICE_POS];
    assign pulldown_ctrl_bit_o         = req_r[PULLDOWN_POS];
    assign regulator_current_monitor_o = req_r[MON_HI:MON_LO];
    assign loop_diag_request_o         = req_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    loop_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (loop_test_done_i && !safing_machine_reset_i) |=> res_r[RES_LOOP_POS] == $past(loops_shorted_flag_i))
        else $error("loops shorted flag not taken");
    ground_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (leak_test_done_i && !safing_machine_reset_i) |=> res_r[RES_GND_POS] == $past(ground_short_flag_i))
        else $error("ground short flag not taken");
    battery_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (leak_test_done_i && !safing_machine_reset_i) |=> res_r[RES_BAT_POS] == $past(battery_short_flag_i))
        else $error("battery short flag not taken");
    pin_bit_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (leak_test_done_i && !safing_machine_reset_i) |=> res_r[RES_PIN_POS] == $past(tested_pin_bit_i))
        else $error("tested pin bit not taken");
    leak_field_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (leak_test_done_i && !safing_machine_reset_i)
        |=> res_r[RES_LEAK_HI:RES_LEAK_LO] == $past(leakage_channel_field_i))
        else $error("leakage channel field not taken");
    result_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!leak_test_done_i && !loop_test_done_i && !safing_machine_reset_i) |=> $stable(res_r))
        else $error("result changed without a cause");
    result_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        safing_machine_reset_i |=> (res_r == RESULT_RST) && (req_r == REQUEST_RST))
        else $error("safing reset did not clear registers");
    request_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!wr_req && !safing_machine_reset_i) |=> $stable(req_r))
        else $error("request changed without a write");
    source_sel_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (low_level && src_code == SRC_40MA && res_ch < 4'h4) ##1 $stable(req_r)
        |-> source_40ma_en_o == (4'h1 << $past(res_ch)))
        else $error("40 mA source on wrong channel");
    source_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (src_code == SRC_OFF || src_code == 2'h3 || res_ch > 4'h3)
        |=> (source_40ma_en_o == '0) && (source_bypass_en_o == '0))
        else $error("source on while switched off");
    sink_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !req_r[SINK_POS] |=> sink_en_o == '0)
        else $error("sink on with sink bit clear");
    readback_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (frame_ok && rx_addr == ADDR_REQUEST) |=> tx_r[19:16] == 4'h0)
        else $error("request read-back top bits not zero");
endmodule
`default_nettype wire

/* testbench/sldr_host.sv */
// Host microcontroller model: SPI master in mode 0 driving the register bank
`timescale 1ns/1ps
`default_nettype none
module sldr_host (
    input  wire logic clock_i,
    input  wire logic spi_miso_i,
    output logic      spi_sclk_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o
);
    // Half period of the serial clock in system clocks, above the 3-cycle minimum
    localparam int HALF = 4;
    // Idle state: serial clock parked low, device deselected
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // One frame of nbits bits, MSB first; a count below 32 must be refused
    task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        spi_cs_n_o <= 1'b0;
        repeat (HALF) @(posedge clock_i);
        for (int i = 31; i > 31 - nbits; i--) begin
            spi_mosi_o <= tx[i];
            repeat (HALF) @(posedge clock_i);
            rx[i] = spi_miso_i; // Settled one system clock before the rising serial edge
            spi_sclk_o <= 1'b1;
            repeat (HALF) @(posedge clock_i);
            spi_sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge clock_i);
        spi_cs_n_o <= 1'b1;
        spi_mosi_o <= ~spi_mosi_o; // Data line is meaningless once deselected
        repeat (2 * HALF) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

/* testbench/squib_loop_diag_regs_tb.sv */
// Self-checking testbench for the squib loop diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module squib_loop_diag_regs_tb;
    import sldr_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sclk, cs_n, mosi, miso;
    logic        ssr = 1'b0;
    logic        loop_done = 1'b0;
    logic        leak_done = 1'b0;
    logic        loops_flag = 1'b0, gnd = 1'b0, bat = 1'b0, pin = 1'b0;
    logic [3:0]  leak_ch = 4'h0;
    logic [3:0]  src40, byp, sink, leaksel;
    logic        lowcur, pd;
    logic [1:0]  mon;
    logic [19:0] req, d, last_res;
    logic [31:0] rx, seed;
    logic [7:0]  v8;
    logic [1:0]  dn;
    int          fail_count = 0;
    int          total_checks = 0;
    // 25 MHz system clock
    always #20 clock_i = ~clock_i;
    sldr_regs u_sldr_regs (
        .clock_i(clock_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .safing_machine_reset_i(ssr),
        .loop_test_done_i(loop_done), .loops_shorted_flag_i(loops_flag),
        .leak_test_done_i(leak_done), .ground_short_flag_i(gnd), .battery_short_flag_i(bat),
        .tested_pin_bit_i(pin), .leakage_channel_field_i(leak_ch), .source_40ma_en_o(src40),
        .source_bypass_en_o(byp), .source_low_current_o(lowcur), .sink_en_o(sink),
        .leak_channel_sel_o(leaksel), .pulldown_ctrl_bit_o(pd),
        .regulator_current_monitor_o(mon), .loop_diag_request_o(req)
    );
    sldr_host u_sldr_host (
        .clock_i(clock_i), .spi_miso_i(miso), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi)
    );
    // ------------------------------------------------------------
    // Comparison, expectation and bus helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Channel code to one-hot select; codes above 3 pick no channel
    function automatic logic [3:0] sel(input logic [3:0] c);
        return (c < 4'h4) ? (4'h1 << c[1:0]) : 4'h0;
    endfunction
    // Expected result after an outcome: each done pulse loads only its own fields
    function automatic logic [19:0] merge(input logic [19:0] old, input logic [7:0] v, input logic [1:0] pulse);
        logic [19:0] m;
        m = old;
        if (pulse[1]) begin
            m[RES_LOOP_POS] = v[7];
        end
        if (pulse[0]) begin
            m[RES_GND_POS:RES_LEAK_LO] = v[6:0];
        end
        return m;
    endfunction
    // Compare the request-driven outputs against the register value v; lowcur, pd and mon only while bit 15 is clear
    task automatic chk_req(input logic [19:0] v);
        logic [3:0] r, l;
        r = v[15] ? 4'h0 : sel(v[7:4]);
        l = v[15] ? 4'h0 : sel(v[3:0]);
        check(32'(req), 32'(v));
        check(32'(src40), 32'((v[12:11] == SRC_40MA) ? r : 4'h0));
        check(32'(byp), 32'((v[12:11] == SRC_BYPASS) ? r : 4'h0));
        check(32'(sink), 32'(v[10] ? r : 4'h0));
        check(32'(leaksel), 32'(l));
        if (!v[15]) begin
            check(32'({lowcur, pd, mon}), 32'({v[14:13], v[9:8]}));
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [19:0] v);
        logic [31:0] junk;
        u_sldr_host.frame({1'b1, a, 4'h0, v}, 32, junk);
    endtask
    // The answer to a frame arrives in the next one, so read twice
    task automatic rd(input logic [6:0] a, output logic [31:0] r);
        logic [31:0] junk;
        u_sldr_host.frame({1'b0, a, 24'h0}, 32, junk);
        u_sldr_host.frame({1'b0, a, 24'h0}, 32, r);
    endtask
    // Diagnostic outcome: pulse[1] marks the loop test done, pulse[0] the leakage test done
    task automatic outcome(input logic [7:0] v, input logic [1:0] pulse);
        {loops_flag, gnd, bat, pin, leak_ch} <= v;
        leak_done <= pulse[0];
        loop_done <= pulse[1];
        @(posedge clock_i);
        leak_done <= 1'b0;
        loop_done <= 1'b0;
        {loops_flag, gnd, bat, pin, leak_ch} <= ~v;
        @(posedge clock_i);
    endtask
    task automatic wrap_up;
        $display("Checks made %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h4879;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk_req(REQUEST_RST);
        rd(ADDR_RESULT, rx);
        check(rx, {1'b0, ADDR_RESULT, 4'h0, RESULT_RST});
        // Corner grid of source codes against channels first, then free random values
        for (int k = 0; k < 24; k++) begin
            d = 20'($random(seed));
            if (k < 16) begin
                d[15] = 1'b0;
                d[12:11] = 2'(k);
                d[7:4] = 4'(k >> 2);
            end
            wr(ADDR_REQUEST, d);
            chk_req(d & REQUEST_WMSK);
            rd(ADDR_REQUEST, rx);
            check(rx, {1'b0, ADDR_REQUEST, 4'h0, d & REQUEST_WMSK});
        end
        // A 31-bit write to the request register must leave it untouched
        u_sldr_host.frame({1'b1, ADDR_REQUEST, 4'h0, ~d}, 31, rx);
        chk_req(d & REQUEST_WMSK);
        // Outcomes with either done pulse alone or both, ending with both pulses, all four flags set and leakage channel 3
        last_res = RESULT_RST;
        for (int k = 0; k < 8; k++) begin
            v8 = (k == 7) ? 8'hf3 : 8'($random(seed));
            dn = (k == 7) ? 2'h3 : 2'($random(seed));
            last_res = merge(last_res, v8, dn);
            outcome(v8, dn);
            rd(ADDR_RESULT, rx);
            check(rx, {1'b0, ADDR_RESULT, 4'h0, last_res});
        end
        wr(ADDR_RESULT, 20'hfffff);
        rd(ADDR_RESULT, rx);
        check(rx, {1'b0, ADDR_RESULT, 4'h0, last_res});
        ssr <= 1'b1;
        @(posedge clock_i);
        ssr <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk_req(REQUEST_RST);
        rd(ADDR_RESULT, rx);
        check(rx, {1'b0, ADDR_RESULT, 4'h0, RESULT_RST});
        wrap_up;
    end
    // Watchdog sized well beyond the roughly 26k cycles the sequence needs
    initial begin
        repeat (60000) @(posedge clock_i);
        fail_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
